// ---- pkg/rtc_cal_pkg.sv ----
package rtc_cal_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int OSC_FREQ_HZ = 32768;
  localparam int STAGE_512_HZ = 512;
  localparam int OSC_DIV = OSC_FREQ_HZ / STAGE_512_HZ;
  localparam logic [5:0] OSC_DIV_LAST = 6'(OSC_DIV - 1);
  localparam logic [9:0] HUNDRED_PULSES = 10'h064;
  localparam logic [9:0] WIN_NORMAL = 10'h200;
  localparam logic [9:0] WIN_FAST = 10'h1ff;
  localparam logic [9:0] WIN_SLOW = 10'h201;
  localparam logic [5:0] SEC_LAST = 6'h3b;
  localparam logic [3:0] CYCLE_LAST_POS = 4'h7;
  localparam logic [3:0] CYCLE_LAST_NEG = 4'hf;

  // ************************************************************
  // register map: index, byte address = index * 4
  // ************************************************************
  localparam int APB_AW = 12;
  localparam logic [9:0] DIG_CAL_IDX = 10'h008;
  localparam logic [9:0] ANA_CAL_IDX = 10'h012;
  localparam logic [9:0] STATUS_IDX = 10'h020;
  localparam logic [11:0] DIG_CAL_ADDR = {DIG_CAL_IDX, 2'b00};
  localparam logic [11:0] ANA_CAL_ADDR = {ANA_CAL_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [7:0] DIG_CAL_RESET = 8'h00;
  localparam logic [7:0] ANA_CAL_RESET = 8'h00;

  // ************************************************************
  // fields
  // ************************************************************
  localparam int DIG_OUT_BIT = 7;
  localparam int DIG_FT_BIT = 6;
  localparam int DIG_SIGN_BIT = 5;
  localparam int MAG_W = 5;
  localparam int ANA_SIGN_BIT = 7;
  localparam int TRIM_W = 7;
  localparam int ST_SEC_LSB = 0;
  localparam int ST_MIN_LSB = 8;
  localparam int ST_CORR_BIT = 12;
  localparam int ST_SIGN_BIT = 13;
  localparam int ST_MAG_LSB = 16;

  // ************************************************************
  // load capacitance, quarter picofarad units
  // ************************************************************
  localparam logic [7:0] CAP_DEFAULT_Q = 8'h64;
  localparam logic [6:0] CAP_ADD_MAX_Q = 7'h27;
  localparam logic [6:0] CAP_REMOVE_MAX_Q = 7'h48;

endpackage

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import rtc_cal_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic osc_in = 1'b0;
  logic osc_run = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hundredths_tick;
  logic second_tick;
  logic freq_test_output;
  logic [7:0] input_side_load_cap;
  logic [7:0] output_side_load_cap;
  logic ft_prev = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_hund = 0;
  int n_sec = 0;
  int n_ft = 0;

  rtc_digital_calibration rtc_digital_calibration_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_in(osc_in), .hundredths_tick(hundredths_tick), .second_tick(second_tick),
    .freq_test_output(freq_test_output), .input_side_load_cap(input_side_load_cap),
    .output_side_load_cap(output_side_load_cap)
  );

  // ************************************************************
  // clock, oscillator at 4 pclk period, event counters
  // ************************************************************
  always #20 pclk = ~pclk;
  logic osc_half = 1'b0;
  always @(posedge pclk) begin
    osc_half <= ~osc_half;
    if (osc_run && osc_half) begin
      osc_in <= ~osc_in;
    end
    ft_prev <= freq_test_output;
    if (hundredths_tick === 1'b1) begin
      n_hund <= n_hund + 1;
    end
    if (second_tick === 1'b1) begin
      n_sec <= n_sec + 1;
    end
    if (freq_test_output === 1'b1 && ft_prev === 1'b0) begin
      n_ft <= n_ft + 1;
    end
  end

  // ************************************************************
  // report and compare
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  initial begin
    #(100000 * 40);
    n_mismatch++;
    $display("ERROR watchdog expected finish seen timeout");
    final_report();
  end

  // ************************************************************
  // apb master
  // ************************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] cap_exp(input logic [7:0] v);
    if (v[7] && v[6:0] <= CAP_REMOVE_MAX_Q) return 8'h64 - {1'b0, v[6:0]};
    if (!v[7] && v[6:0] <= CAP_ADD_MAX_Q) return 8'h64 + {1'b0, v[6:0]};
    return 8'h64;
  endfunction

  task automatic check_caps(input logic [7:0] exp);
    check_val("input_side_load_cap", {24'h0, exp}, {24'h0, input_side_load_cap});
    check_val("output_side_load_cap", {24'h0, exp}, {24'h0, output_side_load_cap});
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  logic [7:0] ana_tab [12] = '{8'h00, 8'h80, 8'h0c, 8'h14, 8'h9c, 8'h27,
                               8'h28, 8'hc8, 8'hc9, 8'h7f, 8'hff, 8'ha7};
  initial begin
    logic [31:0] rd;
    logic err;
    logic [7:0] v;
    int seed;
    int h0;
    seed = $urandom(32'h5d249f03);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_caps(8'h64);
    check_val("pready", 32'h1, {31'h0, pready});
    apb(1'b0, DIG_CAL_ADDR, 32'h0, rd, err);
    check_val("digital reset", 32'h0, rd);
    apb(1'b0, ANA_CAL_ADDR, 32'h0, rd, err);
    check_val("analog reset", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h20 : 8'($urandom);
      apb(1'b1, DIG_CAL_ADDR, {24'($urandom), v}, rd, err);
      apb(1'b0, DIG_CAL_ADDR, 32'h0, rd, err);
      check_val("digital readback", {24'h0, v}, rd);
      check_val("digital pslverr", 32'h0, {31'h0, err});
    end
    apb(1'b0, 12'h004, 32'h0, rd, err);
    check_val("unmapped read data", 32'h0, rd);
    check_val("unmapped pslverr", 32'h1, {31'h0, err});
    apb(1'b1, STATUS_ADDR, 32'hffff_ffff, rd, err);
    check_val("status write pslverr", 32'h1, {31'h0, err});
    apb(1'b1, 12'hffc, 32'h0000_0033, rd, err);
    check_val("unmapped write pslverr", 32'h1, {31'h0, err});
    apb(1'b0, DIG_CAL_ADDR, 32'h0, rd, err);
    check_val("digital after bad write", {24'h0, v}, rd);
    for (int i = 0; i < 18; i++) begin
      v = (i < 12) ? ana_tab[i] : 8'($urandom);
      apb(1'b1, ANA_CAL_ADDR, {24'h0, v}, rd, err);
      repeat (3) @(posedge pclk);
      check_caps(cap_exp(v));
      apb(1'b0, ANA_CAL_ADDR, 32'h0, rd, err);
      check_val("analog readback", {24'h0, v}, rd);
    end
    apb(1'b1, DIG_CAL_ADDR, 32'h80, rd, err);
    repeat (3) @(posedge pclk);
    check_val("ft output level high", 32'h1, {31'h0, freq_test_output});
    apb(1'b1, DIG_CAL_ADDR, 32'h00, rd, err);
    repeat (3) @(posedge pclk);
    check_val("ft output level low", 32'h0, {31'h0, freq_test_output});
    // last calibration write, no cycle boundary falls inside the run
    apb(1'b1, DIG_CAL_ADDR, 32'h7f, rd, err);
    osc_run <= 1'b1;
    repeat (300) @(posedge pclk);
    h0 = n_ft;
    repeat (256 * 40) @(posedge pclk);
    check_range("ft 512 Hz edges", 40, 40, n_ft - h0);
    h0 = n_ft;
    while (n_ft == h0) @(posedge pclk);
    h0 = n_hund;
    for (int k = 0; k < 128; k++) begin
      int b;
      b = n_ft;
      while (n_ft == b) @(posedge pclk);
    end
    check_range("hundredths per 128 stage ticks", 25, 25, n_hund - h0);
    check_range("second ticks before a second", 0, 0, n_sec);
    apb(1'b0, STATUS_ADDR, 32'h0, rd, err);
    check_val("status before boundary", 32'h0, rd);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_caps(8'h64);
    apb(1'b0, DIG_CAL_ADDR, 32'h0, rd, err);
    check_val("digital after reset", 32'h0, rd);
    final_report();
  end
endmodule

// ---- src/mod_counter.sv ----
`timescale 1ns/1ps
// ************************************************************
// modulo counter with run time limit
// ************************************************************
module mod_counter #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [WIDTH-1:0] limit,
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    wrap = tick && (count_reg >= limit);
    count_next = count_reg;
    if (wrap) begin
      count_next = '0;
    end else if (tick) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule

// ---- src/rtc_digital_calibration.sv ----
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// Behaviour
// RULE_01 - time base is the 32768 Hz oscillator divided down to 512 Hz
// RULE_02 - uncorrected second: 100 output pulses per 512 input pulses
// RULE_03 - corrected second with sign one: 100 pulses per 511 inputs
// RULE_04 - corrected second with sign zero: 100 pulses per 513 inputs
// RULE_05 - correct first N seconds of 8 (positive) or 16 (negative) minute cycle
// RULE_06 - magnitude is five unsigned bits, low bits of digital register
// RULE_07 - bit above magnitude: one speeds up, zero slows down
// RULE_08 - zero magnitude never alters the division, whatever the sign
// RULE_09 - each magnitude step gives about +4.068 or -2.034 ppm
// RULE_10 - frequency test output is taken before the corrected stage
// RULE_11 - software rewrites calibration at most once per cycle length
// RULE_12 - analog register trims each load capacitor in quarter pF steps
// RULE_13 - analog top bit: zero adds capacitance, one removes it
// RULE_14 - invalid analog setting falls back to 25 pF per side
// RULE_15 - minute counter marks cycle start, aligned to seconds counter
// RULE_16 - new calibration value takes effect at next cycle boundary
module rtc_digital_calibration
  import rtc_cal_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_in,
  output logic hundredths_tick,
  output logic second_tick,
  output logic freq_test_output,
  output logic [7:0] input_side_load_cap,
  output logic [7:0] output_side_load_cap
);

  // ************************************************************
  // oscillator and 512 hz stage
  // ************************************************************
  logic osc_s;
  logic osc_d_reg;
  logic osc_d_next;
  logic osc_rise;
  logic [5:0] osc_cnt;
  logic tick512;

  sync2 u_osc_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(osc_in),
    .sync_out(osc_s)
  );

  always_comb begin
    osc_d_next = osc_s;
    osc_rise = osc_s && !osc_d_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_d_reg <= 1'b0;
    end else begin
      osc_d_reg <= osc_d_next;
    end
  end

  mod_counter #(.WIDTH(6)) u_osc_div ( // RULE_01
    .clk(pclk),
    .rst_n(presetn),
    .tick(osc_rise),
    .limit(OSC_DIV_LAST),
    .count(osc_cnt),
    .wrap(tick512)
  );

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] dig_reg;
  logic [7:0] dig_next;
  logic [7:0] ana_reg;
  logic [7:0] ana_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] status_word;
  logic setup_phase;
  logic wr_access;

  // ************************************************************
  // calibration state
  // ************************************************************
  logic act_sign_reg;
  logic act_sign_next;
  logic [MAG_W-1:0] act_mag_reg;
  logic [MAG_W-1:0] act_mag_next;
  logic [9:0] win_cnt_reg;
  logic [9:0] win_cnt_next;
  logic [9:0] acc_reg;
  logic [9:0] acc_next;
  logic [10:0] acc_sum;
  logic [9:0] window;
  logic corrected;
  logic sec_end;
  logic emit;
  logic emit_reg;
  logic sec_end_reg;
  logic [5:0] sec_cnt;
  logic sec_wrap;
  logic [3:0] cyc_min;
  logic min_wrap;
  logic [3:0] cyc_last;
  logic boundary;

  // ************************************************************
  // apb slave
  // ************************************************************
  always_comb begin
    setup_phase = psel && !penable;
    wr_access = psel && penable && pwrite;
    dig_next = dig_reg;
    ana_next = ana_reg;
    if (wr_access && paddr == DIG_CAL_ADDR) begin
      dig_next = pwdata[7:0]; // RULE_06
    end
    if (wr_access && paddr == ANA_CAL_ADDR) begin
      ana_next = pwdata[7:0]; // RULE_12
    end
    status_word = 32'h0000_0000;
    status_word[ST_SEC_LSB +: 6] = sec_cnt;
    status_word[ST_MIN_LSB +: 4] = cyc_min;
    status_word[ST_CORR_BIT] = corrected;
    status_word[ST_SIGN_BIT] = act_sign_reg;
    status_word[ST_MAG_LSB +: MAG_W] = act_mag_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        DIG_CAL_ADDR: prdata_next = {24'h00_0000, dig_reg};
        ANA_CAL_ADDR: prdata_next = {24'h00_0000, ana_reg};
        STATUS_ADDR: prdata_next = status_word;
        default: pslverr_next = 1'b1;
      endcase
      if (pwrite) begin
        prdata_next = 32'h0000_0000;
        if (paddr == STATUS_ADDR) begin
          pslverr_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_reg <= DIG_CAL_RESET;
      ana_reg <= ANA_CAL_RESET;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      dig_reg <= dig_next;
      ana_reg <= ana_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // ************************************************************
  // 100 hz stage and cycle counters
  // ************************************************************
  mod_counter #(.WIDTH(6)) u_sec ( // RULE_15
    .clk(pclk),
    .rst_n(presetn),
    .tick(sec_end),
    .limit(SEC_LAST),
    .count(sec_cnt),
    .wrap(sec_wrap)
  );

  mod_counter #(.WIDTH(4)) u_cycle_min ( // RULE_15
    .clk(pclk),
    .rst_n(presetn),
    .tick(sec_wrap),
    .limit(cyc_last),
    .count(cyc_min),
    .wrap(min_wrap)
  );

  always_comb begin
    cyc_last = act_sign_reg ? CYCLE_LAST_POS : CYCLE_LAST_NEG; // RULE_05 RULE_09
    corrected = (act_mag_reg != '0) && (cyc_min == 4'h0) && // RULE_08
                (sec_cnt < {1'b0, act_mag_reg}); // RULE_05
    if (!corrected) begin
      window = WIN_NORMAL; // RULE_02
    end else if (act_sign_reg) begin
      window = WIN_FAST; // RULE_03 RULE_07
    end else begin
      window = WIN_SLOW; // RULE_04 RULE_07
    end
    acc_sum = {1'b0, acc_reg} + {1'b0, HUNDRED_PULSES};
    emit = tick512 && (acc_sum >= {1'b0, window});
    sec_end = tick512 && (win_cnt_reg == window - 10'h001);
    boundary = min_wrap;
    win_cnt_next = win_cnt_reg;
    acc_next = acc_reg;
    if (tick512) begin
      win_cnt_next = sec_end ? 10'h000 : win_cnt_reg + 10'h001;
      acc_next = emit ? 10'(acc_sum - {1'b0, window}) : acc_sum[9:0];
      if (sec_end) begin
        acc_next = 10'h000;
      end
    end
    act_sign_next = act_sign_reg;
    act_mag_next = act_mag_reg;
    if (boundary) begin
      act_sign_next = dig_reg[DIG_SIGN_BIT]; // RULE_16
      act_mag_next = dig_reg[MAG_W-1:0]; // RULE_16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt_reg <= 10'h000;
      acc_reg <= 10'h000;
      act_sign_reg <= 1'b0;
      act_mag_reg <= '0;
      emit_reg <= 1'b0;
      sec_end_reg <= 1'b0;
    end else begin
      win_cnt_reg <= win_cnt_next;
      acc_reg <= acc_next;
      act_sign_reg <= act_sign_next;
      act_mag_reg <= act_mag_next;
      emit_reg <= emit;
      sec_end_reg <= sec_end;
    end
  end

  assign hundredths_tick = emit_reg;
  assign second_tick = sec_end_reg;

  // ************************************************************
  // frequency test and load capacitors
  // ************************************************************
  logic ft_reg;
  logic ft_next;
  logic [7:0] cap_reg;
  logic [7:0] cap_next;
  logic [TRIM_W-1:0] trim;

  always_comb begin
    ft_next = dig_reg[DIG_OUT_BIT];
    if (dig_reg[DIG_FT_BIT]) begin
      ft_next = osc_cnt[5]; // RULE_10
    end
    trim = ana_reg[TRIM_W-1:0];
    cap_next = CAP_DEFAULT_Q; // RULE_14
    if (ana_reg[ANA_SIGN_BIT]) begin
      if (trim <= CAP_REMOVE_MAX_Q) begin
        cap_next = CAP_DEFAULT_Q - {1'b0, trim}; // RULE_13
      end
    end else if (trim <= CAP_ADD_MAX_Q) begin
      cap_next = CAP_DEFAULT_Q + {1'b0, trim}; // RULE_13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft_reg <= 1'b0;
      cap_reg <= CAP_DEFAULT_Q;
    end else begin
      ft_reg <= ft_next;
      cap_reg <= cap_next;
    end
  end

  assign freq_test_output = ft_reg;
  assign input_side_load_cap = cap_reg;
  assign output_side_load_cap = cap_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  logic [6:0] hcount_reg;
  logic [6:0] hcount_next;

  always_comb begin
    hcount_next = hcount_reg;
    if (sec_end) begin
      hcount_next = 7'h00;
    end else if (emit) begin
      hcount_next = hcount_reg + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcount_reg <= 7'h00;
    end else begin
      hcount_reg <= hcount_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hundred_per_sec: assert property (sec_end |-> hcount_reg + 7'(emit) == 7'd100) // RULE_02
    else $error("second did not carry 100 pulses");
  a_normal_window: assert property (sec_end && !corrected |-> win_cnt_reg == 10'd511) // RULE_02
    else $error("uncorrected second not 512 inputs");
  a_fast_window: assert property (sec_end && corrected && act_sign_reg |-> win_cnt_reg == 10'd510) // RULE_03
    else $error("fast second not 511 inputs");
  a_slow_window: assert property (sec_end && corrected && !act_sign_reg |-> win_cnt_reg == 10'd512) // RULE_04
    else $error("slow second not 513 inputs");
  a_zero_magnitude: assert property (act_mag_reg == 5'd0 |-> !corrected) // RULE_08
    else $error("zero magnitude corrected");
  a_corr_span: assert property (corrected |-> cyc_min == 4'd0 && sec_cnt < 6'(act_mag_reg)) // RULE_05
    else $error("correction outside first seconds");
  a_cycle_length: assert property (min_wrap |-> cyc_min == (act_sign_reg ? 4'd7 : 4'd15)) // RULE_15
    else $error("cycle length wrong");
  a_cal_hold: assert property (!boundary |=> $stable(act_mag_reg) && $stable(act_sign_reg)) // RULE_16
    else $error("calibration changed mid cycle");
  a_osc_divide: assert property (tick512 |-> osc_cnt == 6'd63 && osc_rise) // RULE_01
    else $error("512 hz stage not divide by 64");
  a_dig_write: assert property (wr_access && paddr == DIG_CAL_ADDR |=> dig_reg == $past(pwdata[7:0])) // RULE_06
    else $error("digital register write lost");
  a_ana_write: assert property (wr_access && paddr == ANA_CAL_ADDR |=> ana_reg == $past(pwdata[7:0])) // RULE_12
    else $error("analog register write lost");
  a_cap_default: assert property (ana_reg[7] && ana_reg[6:0] > 7'd72 |=> cap_reg == 8'd100) // RULE_14
    else $error("invalid trim not default");
  a_cap_sign: assert property (!ana_reg[7] |=> cap_reg >= 8'd100) // RULE_13
    else $error("sign zero removed capacitance");
  a_ft_source: assert property (dig_reg[6] ##1 dig_reg[6] |-> freq_test_output == $past(osc_cnt[5])) // RULE_10
    else $error("test output not from divider");

  c_fast_second: cover property (sec_end && corrected && act_sign_reg);
  c_slow_second: cover property (sec_end && corrected && !act_sign_reg);
  c_boundary: cover property (boundary && dig_reg[4:0] != 5'd0);
  c_invalid_trim: cover property (ana_reg[7] && ana_reg[6:0] > 7'd72);

endmodule

// ---- src/sync2.sv ----
`timescale 1ns/1ps
// ************************************************************
// two stage synchroniser
// ************************************************************
module sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
